// ===== rtl/ccpc_port_config.sv
// per-receive-port control channel and forward path configuration registers
//
// Notes on behaviour
// - accesses reach the copy of the port named by the port select register
// - forward_all passes every local transaction to the serializer; resets to zero
// - forward_decode passes a transaction only when its address decode matches
// - ack_uncond acknowledges forwarded writes locally, otherwise remote answer is relayed
// - forced-on bit, reset one, keeps the return link enabled regardless
// - with forced-on clear, return link runs only if a pass-through bit is set
// - forced-on bit is writable only locally; control channel writes leave it
// - return link check generation follows its enable bit, which resets to one
// - rate field is loaded from the strap when the powerdown pin rises
// - rate codes: 000, 010, 101, 110 valid; others flagged reserved
// - after a rate change the return link may show errors for a while
// - hold bit blocks forward channel loading of path settings; resets to zero
// - gpio count code 00,01,10,11 means none, one, two, four lines
// - gpio count normally follows configuration from the remote serializer
// - a local gpio count write lasts only while the hold bit is one
`timescale 1ns/1ps
`default_nettype none
module ccpc_port_config
   import ccpc_pkg::*;
#(
   parameter int NUM_PORTS  = 2,
   parameter int SETTLE_CYC = CCPC_RATE_SETTLE_CYC,
   parameter int SEL_W      = (NUM_PORTS > 1) ? $clog2(NUM_PORTS) : 1
) (
   input  wire logic                              core_clk,
   input  wire logic                              rst,
   input  wire logic [SEL_W-1:0]                  port_sel,
   input  wire ccpc_req_t                         req,
   output logic                                   addr_hit,
   output logic                                   rd_valid,
   output logic [7:0]                             rd_data,
   input  wire logic                              powerdown_n_pin,
   input  wire logic [2:0]                        strap_rate,
   input  wire logic                              fc_valid,
   input  wire logic [SEL_W-1:0]                  fc_port,
   input  wire logic [1:0]                        fc_gpio_count,
   output ccpc_port_ctrl_t [NUM_PORTS-1:0]        port_ctrl
);

   localparam int CNT_W = $clog2(SETTLE_CYC + 1);

   generate
      if (NUM_PORTS < 1 || NUM_PORTS > (1 << SEL_W) || SETTLE_CYC < 1) begin : g_bad_cfg
         $error("ccpc_port_config: unsupported NUM_PORTS or SETTLE_CYC");
      end
   endgenerate

   logic [7:0]       cc_cfg_q   [NUM_PORTS];
   logic [7:0]       path_one_q [NUM_PORTS];
   logic [7:0]       path_two_q [NUM_PORTS];
   logic [CNT_W-1:0] settle_q   [NUM_PORTS];
   logic             pdn_q;
   logic             rd_valid_q;
   logic [7:0]       rd_data_q;

   // 0: none, 1: config, 2: path one, 3: path two; used by both read and write paths
   function automatic logic [1:0] reg_sel(input logic [7:0] a);
      case (a)
         CCPC_CC_CFG_OFS:   reg_sel = 2'h1;
         CCPC_PATH_ONE_OFS: reg_sel = 2'h2;
         CCPC_PATH_TWO_OFS: reg_sel = 2'h3;
         default:           reg_sel = 2'h0;
      endcase
   endfunction

   // gpio code to number of enabled lines
   function automatic logic [2:0] gpio_lines(input logic [1:0] c);
      case (c)
         2'h0:    gpio_lines = 3'h0;
         2'h1:    gpio_lines = 3'h1;
         2'h2:    gpio_lines = 3'h2;
         default: gpio_lines = 3'h4;
      endcase
   endfunction

   function automatic logic rate_is_reserved(input logic [2:0] r);
      rate_is_reserved = !(r == CCPC_RATE_2M5 || r == CCPC_RATE_10M || r == CCPC_RATE_25M || r == CCPC_RATE_50M);
   endfunction

   assign addr_hit = (reg_sel(req.addr) != 2'h0);

   // powerdown pin history for the strap capture edge
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pdn_q <= 1'b0;
      end else begin
         pdn_q <= powerdown_n_pin;
      end
   end

   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      logic sel_me;
      logic cfg_wr;
      logic one_wr;
      logic rate_chg;
      assign sel_me   = (port_sel == SEL_W'(p));
      assign cfg_wr   = req.wr && sel_me && (reg_sel(req.addr) == 2'h1);
      assign one_wr   = req.wr && sel_me && (reg_sel(req.addr) == 2'h2);
      assign rate_chg = cfg_wr && (req.wdata[CCPC_RATE_MSB:CCPC_RATE_LSB] != cc_cfg_q[p][CCPC_RATE_MSB:CCPC_RATE_LSB]);

      // control channel config; a later write in the same cycle wins over the strap
      always_ff @(posedge core_clk) begin
         if (rst) begin
            cc_cfg_q[p] <= CCPC_CC_CFG_RST;
         end else begin
            if (powerdown_n_pin && !pdn_q) begin
               cc_cfg_q[p][CCPC_RATE_MSB:CCPC_RATE_LSB] <= strap_rate;
            end
            if (cfg_wr) begin
               cc_cfg_q[p][7:5] <= req.wdata[7:5];
               cc_cfg_q[p][3:0] <= req.wdata[3:0];
               // while the forced-on bit is set, remote masters cannot switch the return link off behind the host's back
               if (!req.remote) begin
                  cc_cfg_q[p][CCPC_FORCED_BIT] <= req.wdata[CCPC_FORCED_BIT];
               end
            end
         end
      end

      // path control one; the forward channel overrides a local gpio write unless held
      always_ff @(posedge core_clk) begin
         if (rst) begin
            path_one_q[p] <= CCPC_PATH_ONE_RST;
         end else begin
            if (one_wr) begin
               path_one_q[p] <= req.wdata;
            end
            if (fc_valid && fc_port == SEL_W'(p) && !path_one_q[p][CCPC_HOLD_BIT]) begin
               path_one_q[p][CCPC_GPIO_MSB:CCPC_GPIO_LSB] <= fc_gpio_count;
            end
         end
      end

      // path control two holds reserved bits only
      always_ff @(posedge core_clk) begin
         if (rst) begin
            path_two_q[p] <= CCPC_PATH_TWO_RST;
         end else if (req.wr && sel_me && reg_sel(req.addr) == 2'h3) begin
            path_two_q[p] <= req.wdata;
         end
      end

      // settle window after a rate change; consumers mask return-link errors meanwhile
      always_ff @(posedge core_clk) begin
         if (rst) begin
            settle_q[p] <= '0;
         end else if (rate_chg) begin
            settle_q[p] <= CNT_W'(SETTLE_CYC);
         end else if (settle_q[p] != '0) begin
            settle_q[p] <= settle_q[p] - CNT_W'(1);
         end
      end

      // outputs decoded from the stored copies
      always_comb begin
         port_ctrl[p].forward_all    = cc_cfg_q[p][CCPC_FWD_ALL_BIT];
         port_ctrl[p].forward_decode = cc_cfg_q[p][CCPC_FWD_DEC_BIT];
         port_ctrl[p].ack_uncond     = cc_cfg_q[p][CCPC_ACK_ALL_BIT];
         port_ctrl[p].return_link_en = cc_cfg_q[p][CCPC_FORCED_BIT]
                                     | cc_cfg_q[p][CCPC_FWD_ALL_BIT]
                                     | cc_cfg_q[p][CCPC_FWD_DEC_BIT];
         port_ctrl[p].crc_gen_en     = cc_cfg_q[p][CCPC_CRC_BIT];
         port_ctrl[p].rate_sel       = cc_cfg_q[p][CCPC_RATE_MSB:CCPC_RATE_LSB];
         // 010 is treated as the 10 Mbps code, not reserved
         port_ctrl[p].rate_reserved  = rate_is_reserved(cc_cfg_q[p][CCPC_RATE_MSB:CCPC_RATE_LSB]);
         port_ctrl[p].settling       = (settle_q[p] != '0);
         port_ctrl[p].hold_local     = path_one_q[p][CCPC_HOLD_BIT];
         port_ctrl[p].gpio_count     = path_one_q[p][CCPC_GPIO_MSB:CCPC_GPIO_LSB];
         port_ctrl[p].gpio_lines     = gpio_lines(path_one_q[p][CCPC_GPIO_MSB:CCPC_GPIO_LSB]);
      end
   end

   // read path: one cycle latency, unmapped offsets or ports read zero
   always_ff @(posedge core_clk) begin
      if (rst) begin
         rd_valid_q <= 1'b0;
         rd_data_q  <= 8'h00;
      end else begin
         rd_valid_q <= req.rd;
         if (req.rd) begin
            rd_data_q <= 8'h00;
            for (int i = 0; i < NUM_PORTS; i++) begin
               if (port_sel == SEL_W'(i)) begin
                  case (reg_sel(req.addr))
                     2'h1:    rd_data_q <= cc_cfg_q[i];
                     2'h2:    rd_data_q <= path_one_q[i];
                     2'h3:    rd_data_q <= path_two_q[i];
                     default: rd_data_q <= 8'h00;
                  endcase
               end
            end
         end
      end
   end

   assign rd_valid = rd_valid_q;
   assign rd_data  = rd_data_q;

   // ---- checks ----
   logic wr0_cfg_local;
   logic wr0_cfg_any;
   assign wr0_cfg_any   = req.wr && port_sel == SEL_W'(0) && req.addr == CCPC_CC_CFG_OFS;
   assign wr0_cfg_local = wr0_cfg_any && !req.remote;

   property p_route_port0;
      @(posedge core_clk) disable iff (rst)
      wr0_cfg_local |=> port_ctrl[0].forward_all == $past(req.wdata[7])
                     && port_ctrl[0].ack_uncond == $past(req.wdata[5]);
   endproperty
   a_route_port0: assert property (p_route_port0) else $error("port 0 config write not applied");

   property p_other_port_kept;
      @(posedge core_clk) disable iff (rst)
      (NUM_PORTS > 1 && wr0_cfg_any) |=> $stable(cc_cfg_q[NUM_PORTS-1][7:3]);
   endproperty
   a_other_port_kept: assert property (p_other_port_kept) else $error("write leaked to other port");

   property p_link_off;
      @(posedge core_clk) disable iff (rst)
      (wr0_cfg_local && req.wdata[7:6] == 2'h0 && !req.wdata[4]) |=> !port_ctrl[0].return_link_en;
   endproperty
   a_link_off: assert property (p_link_off) else $error("return link enabled with all enables clear");

   property p_link_pass;
      @(posedge core_clk) disable iff (rst)
      (wr0_cfg_local && req.wdata[6] && !req.wdata[4]) |=> port_ctrl[0].return_link_en;
   endproperty
   a_link_pass: assert property (p_link_pass) else $error("return link off with pass-through set");

   property p_remote_forced;
      @(posedge core_clk) disable iff (rst)
      (wr0_cfg_any && req.remote) |=> cc_cfg_q[0][CCPC_FORCED_BIT] == $past(cc_cfg_q[0][CCPC_FORCED_BIT]);
   endproperty
   a_remote_forced: assert property (p_remote_forced) else $error("remote write changed forced-on bit");

   property p_reset_vals;
      @(posedge core_clk) $fell(rst) |-> port_ctrl[0].crc_gen_en && port_ctrl[0].return_link_en
                                     && !port_ctrl[0].forward_all && !port_ctrl[0].hold_local;
   endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("wrong reset values");

   property p_strap;
      @(posedge core_clk) disable iff (rst)
      (powerdown_n_pin && !pdn_q && !wr0_cfg_any) |=> port_ctrl[0].rate_sel == $past(strap_rate);
   endproperty
   a_strap: assert property (p_strap) else $error("strap rate not captured");

   property p_settle;
      @(posedge core_clk) disable iff (rst)
      (wr0_cfg_any && req.wdata[2:0] != port_ctrl[0].rate_sel) |=> port_ctrl[0].settling [*8];
   endproperty
   a_settle: assert property (p_settle) else $error("settle window missing after rate change");

   property p_hold_blocks;
      @(posedge core_clk) disable iff (rst)
      (port_ctrl[0].hold_local && fc_valid && fc_port == SEL_W'(0)
       && !(req.wr && port_sel == SEL_W'(0) && req.addr == CCPC_PATH_ONE_OFS)) |=> $stable(port_ctrl[0].gpio_count);
   endproperty
   a_hold_blocks: assert property (p_hold_blocks) else $error("forward channel overwrote held gpio count");

   property p_fc_load;
      @(posedge core_clk) disable iff (rst)
      (!port_ctrl[0].hold_local && fc_valid && fc_port == SEL_W'(0)) |=> port_ctrl[0].gpio_count == $past(fc_gpio_count);
   endproperty
   a_fc_load: assert property (p_fc_load) else $error("forward channel gpio count not loaded");

   property p_read_two;
      @(posedge core_clk) disable iff (rst)
      (req.rd && port_sel == SEL_W'(0) && req.addr == CCPC_PATH_TWO_OFS)
      |=> rd_valid && rd_data == $past(path_two_q[0]); // a write in the read cycle is not yet seen
   endproperty
   a_read_two: assert property (p_read_two) else $error("read data wrong");

   property p_cov_rate;
      @(posedge core_clk) disable iff (rst) wr0_cfg_local ##1 port_ctrl[0].settling;
   endproperty
   c_cov_rate: cover property (p_cov_rate);

   property p_cov_hold;
      @(posedge core_clk) disable iff (rst) port_ctrl[0].hold_local && fc_valid;
   endproperty
   c_cov_hold: cover property (p_cov_hold);

   property p_cov_remote;
      @(posedge core_clk) disable iff (rst) wr0_cfg_any && req.remote;
   endproperty
   c_cov_remote: cover property (p_cov_remote);

   // every read strobe is answered exactly one cycle later, and nothing else raises the strobe
   property p_rd_pulse;
      @(posedge core_clk) disable iff (rst)
      rd_valid == $past(req.rd);
   endproperty
   a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe not answered in one cycle");

   // the top gpio code enables four lines, not three
   property p_lines_four;
      @(posedge core_clk) disable iff (rst)
      port_ctrl[0].gpio_count == 2'h3 |-> port_ctrl[0].gpio_lines == 3'h4;
   endproperty
   a_lines_four: assert property (p_lines_four) else $error("gpio code 11 must enable four lines");

   property p_cov_strap;
      @(posedge core_clk) disable iff (rst) powerdown_n_pin && !pdn_q;
   endproperty
   c_cov_strap: cover property (p_cov_strap);

endmodule
`default_nettype wire

// ===== rtl/ccpc_pkg.sv
// constants and carrier types for the per-port control channel configuration bank
package ccpc_pkg;

   // register offsets
   localparam logic [7:0] CCPC_PORT_SEL_OFS  = 8'h4C; // port select lives outside this bank
   localparam logic [7:0] CCPC_CC_CFG_OFS    = 8'h58; // control_channel_config
   localparam logic [7:0] CCPC_PATH_ONE_OFS  = 8'h59; // path_control_one
   localparam logic [7:0] CCPC_PATH_TWO_OFS  = 8'h5A; // path_control_two

   // control_channel_config fields
   localparam int CCPC_FWD_ALL_BIT  = 7;
   localparam int CCPC_FWD_DEC_BIT  = 6;
   localparam int CCPC_ACK_ALL_BIT  = 5;
   localparam int CCPC_FORCED_BIT   = 4;
   localparam int CCPC_CRC_BIT      = 3;
   localparam int CCPC_RATE_MSB     = 2;
   localparam int CCPC_RATE_LSB     = 0;

   // path_control_one fields
   localparam int CCPC_HOLD_BIT     = 7;
   localparam int CCPC_GPIO_MSB     = 1;
   localparam int CCPC_GPIO_LSB     = 0;

   // reset values; rate bits are replaced by the strap on power-up
   localparam logic [7:0] CCPC_CC_CFG_RST   = 8'h1E;
   localparam logic [7:0] CCPC_PATH_ONE_RST = 8'h00;
   localparam logic [7:0] CCPC_PATH_TWO_RST = 8'h00;

   // return link rate codes
   localparam logic [2:0] CCPC_RATE_2M5 = 3'h0;
   localparam logic [2:0] CCPC_RATE_10M = 3'h2;
   localparam logic [2:0] CCPC_RATE_25M = 3'h5;
   localparam logic [2:0] CCPC_RATE_50M = 3'h6;

   // timing: interval during which return-link errors are expected after a rate change
   localparam int CCPC_CLK_PERIOD_NS  = 20;
   localparam int CCPC_RATE_SETTLE_NS = 10000;
   localparam int CCPC_RATE_SETTLE_CYC = CCPC_RATE_SETTLE_NS / CCPC_CLK_PERIOD_NS;

   // register access request
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic       remote; // 1: arrived over the side control channel
      logic [7:0] addr;
      logic [7:0] wdata;
   } ccpc_req_t;

   // per-port control outputs
   typedef struct packed {
      logic       forward_all;
      logic       forward_decode;
      logic       ack_uncond;
      logic       return_link_en;
      logic       crc_gen_en;
      logic [2:0] rate_sel;
      logic       rate_reserved;
      logic       settling;
      logic       hold_local;
      logic [1:0] gpio_count;
      logic [2:0] gpio_lines;
   } ccpc_port_ctrl_t;

endpackage

// ===== dv/ccpc_serializer_model.sv
// far-side serializer model that ships forward channel path settings
`timescale 1ns/1ps
`default_nettype none
module ccpc_serializer_model
   import ccpc_pkg::*;
(
   input  wire logic  core_clk,
   output logic       fc_valid,
   output logic       fc_port,
   output logic [1:0] fc_gpio_count
);
   // far-side auto-acknowledge flag; nothing in the model reads it, the bench uses it as the remote bit of a write
   logic auto_ack;
   // quiet link until the first beat
   initial begin
      auto_ack = 1'b0;
      fc_valid = 1'b0;
      fc_port = 1'b0;
      fc_gpio_count = 2'h0;
   end
   // one config beat; fields are inverted afterwards so a stale value is never trusted
   task automatic send(input logic p, input logic [1:0] cnt);
      @(negedge core_clk);
      fc_valid = 1'b1;
      fc_port = p;
      fc_gpio_count = cnt;
      @(negedge core_clk);
      fc_valid = 1'b0;
      fc_port = ~p;
      fc_gpio_count = ~cnt;
   endtask
endmodule
`default_nettype wire

// ===== dv/control_channel_port_config_test.sv
// self-checking bench for the per-port configuration bank
`timescale 1ns/1ps
`default_nettype none
module control_channel_port_config_test
   import ccpc_pkg::*;
;
   logic                  core_clk;
   logic                  rst;
   logic                  port_sel;
   ccpc_req_t             req;
   logic                  addr_hit;
   logic                  rd_valid;
   logic [7:0]            rd_data;
   logic                  powerdown_n_pin;
   logic [2:0]            strap_rate;
   logic                  fc_valid;
   logic                  fc_port;
   logic [1:0]            fc_gpio_count;
   ccpc_port_ctrl_t [1:0] pc;
   int                    bad_count;
   int                    n_tests;
   int                    i;

   ccpc_port_config #(.NUM_PORTS(2), .SETTLE_CYC(10)) dut (
      .core_clk(core_clk), .rst(rst), .port_sel(port_sel), .req(req), .addr_hit(addr_hit),
      .rd_valid(rd_valid), .rd_data(rd_data), .powerdown_n_pin(powerdown_n_pin),
      .strap_rate(strap_rate), .fc_valid(fc_valid), .fc_port(fc_port),
      .fc_gpio_count(fc_gpio_count), .port_ctrl(pc));

   ccpc_serializer_model ser (
      .core_clk(core_clk), .fc_valid(fc_valid), .fc_port(fc_port), .fc_gpio_count(fc_gpio_count));

   // 50 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   task automatic complete_run();
      $display("checks %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: byte %h, wanted %h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
      end
   endtask

   // one write, held across exactly one sampling edge
   task automatic wr(input logic s, input logic [7:0] a, input logic [7:0] d, input logic rem);
      @(negedge core_clk);
      port_sel = s;
      req.wr = 1'b1;
      req.remote = rem;
      req.addr = a;
      req.wdata = d;
      @(negedge core_clk);
      req.wr = 1'b0;
      req.remote = 1'b0;
   endtask

   // read with a bounded wait for the data strobe
   task automatic rd(input logic s, input logic [7:0] a, input logic [7:0] exp);
      int n;
      @(negedge core_clk);
      port_sel = s;
      req.rd = 1'b1;
      req.addr = a;
      @(negedge core_clk);
      req.rd = 1'b0;
      n = 0;
      while (rd_valid !== 1'b1 && n < 3) begin
         @(negedge core_clk);
         n++;
      end
      chk1(rd_valid, 1'b1);
      chk8(rd_data, exp);
   endtask

   // a hang costs a mismatch and ends the run in the usual place
   initial begin
      #(20 * 5000);
      bad_count++;
      complete_run();
   end

   initial begin
      bad_count = 0;
      n_tests = 0;
      rst = 1'b1;
      port_sel = 1'b0;
      req = '0;
      powerdown_n_pin = 1'b0;
      strap_rate = 3'h2;
      repeat (5) @(negedge core_clk);
      rst = 1'b0;
      // reset values: config register on port 0, both path registers on port 1
      rd(0, CCPC_CC_CFG_OFS, CCPC_CC_CFG_RST);
      rd(1, CCPC_PATH_ONE_OFS, 8'h00);
      rd(1, CCPC_PATH_TWO_OFS, 8'h00);
      chk1(pc[1].return_link_en, 1'b1);
      chk1(pc[0].crc_gen_en, 1'b1);
      // strap capture on the powerdown pin rising, without settling
      @(negedge core_clk);
      powerdown_n_pin = 1'b1;
      @(negedge core_clk);
      @(negedge core_clk);
      chk8({5'h00, pc[1].rate_sel}, 8'h02);
      chk1(pc[0].settling, 1'b0);
      rd(0, CCPC_CC_CFG_OFS, 8'h1A);
      // per-port copies and return link enable terms
      wr(1, CCPC_CC_CFG_OFS, 8'h82, 0);
      wr(0, CCPC_CC_CFG_OFS, 8'h02, 0);
      chk1(pc[0].return_link_en, 1'b0);
      chk1(pc[0].crc_gen_en, 1'b0);
      chk1(pc[1].return_link_en, 1'b1);
      chk1(pc[1].forward_all, 1'b1);
      rd(1, CCPC_CC_CFG_OFS, 8'h82);
      rd(0, CCPC_CC_CFG_OFS, 8'h02);
      wr(0, CCPC_CC_CFG_OFS, 8'h42, 0);
      chk1(pc[0].forward_decode, 1'b1);
      chk1(pc[0].forward_all, 1'b0);
      chk1(pc[0].return_link_en, 1'b1);
      wr(0, CCPC_CC_CFG_OFS, 8'h22, 0);
      chk1(pc[0].ack_uncond, 1'b1);
      chk1(pc[0].forward_decode, 1'b0);
      // forced-on bit ignores a control channel write that tries to clear it
      wr(0, CCPC_CC_CFG_OFS, 8'h02, 1);
      rd(0, CCPC_CC_CFG_OFS, 8'h02);
      wr(0, CCPC_CC_CFG_OFS, 8'h12, 0);
      wr(0, CCPC_CC_CFG_OFS, 8'hE2, 1);
      rd(0, CCPC_CC_CFG_OFS, 8'hF2);
      // every rate code, each a change, so settling restarts each time
      for (i = 0; i < 8; i++) begin
         wr(0, CCPC_CC_CFG_OFS, 8'h10 | 8'(i), 0);
         chk8({5'h00, pc[0].rate_sel}, 8'(i));
         chk1(pc[0].rate_reserved, (i == 1 || i == 3 || i == 4 || i == 7));
         chk1(pc[0].settling, 1'b1);
      end
      // a rate change over the channel, with the far-side auto-acknowledge flag driven as the remote bit
      ser.auto_ack = 1'b1;
      wr(0, CCPC_CC_CFG_OFS, 8'h15, ser.auto_ack);
      chk8({5'h00, pc[0].rate_sel}, 8'h05);
      chk1(pc[0].settling, 1'b1);
      // the window lasts exactly the settle count of 10 cycles
      repeat (9) @(negedge core_clk);
      chk1(pc[0].settling, 1'b1);
      @(negedge core_clk);
      chk1(pc[0].settling, 1'b0);
      rd(0, CCPC_CC_CFG_OFS, 8'h15);
      // forward channel loads every gpio code while hold is clear
      for (i = 0; i < 4; i++) begin
         ser.send(0, 2'(i));
         chk8({6'h00, pc[0].gpio_count}, 8'(i));
         chk8({5'h00, pc[0].gpio_lines}, (i == 3) ? 8'h04 : 8'(i));
      end
      // local value without hold is overwritten by the next load
      wr(0, CCPC_PATH_ONE_OFS, 8'h01, 0);
      ser.send(0, 2'h2);
      rd(0, CCPC_PATH_ONE_OFS, 8'h02);
      // with hold set the local value survives; the other port still loads
      wr(0, CCPC_PATH_ONE_OFS, 8'h81, 0);
      ser.send(0, 2'h3);
      ser.send(1, 2'h3);
      rd(0, CCPC_PATH_ONE_OFS, 8'h81);
      chk1(pc[0].hold_local, 1'b1);
      chk8({6'h00, pc[1].gpio_count}, 8'h03);
      // spare register storage, a mapped and an unmapped offset
      wr(1, CCPC_PATH_TWO_OFS, 8'hA5, 0);
      rd(1, CCPC_PATH_TWO_OFS, 8'hA5);
      rd(0, CCPC_PATH_TWO_OFS, 8'h00);
      @(negedge core_clk);
      req.addr = CCPC_PATH_ONE_OFS;
      #1;
      chk1(addr_hit, 1'b1);
      req.addr = 8'h57;
      #1;
      chk1(addr_hit, 1'b0);
      rd(0, 8'h57, 8'h00);
      complete_run();
   end
endmodule
`default_nettype wire
